// ### src/tpm_pkg.sv
// ***************************************************************
// shared constants and carriers of the performance event monitors
// ***************************************************************
package tpm_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int NUM_TBU = 2; // buffer unit instances, each with its own monitor
  localparam int NUM_CNT = 2; // counters in every monitor
  localparam int SID_W = 24; // stream identifier width
  localparam int CODE_W = 8; // event code width
  localparam int CNT_W = 32; // counter width
  localparam int WC_NUM = 5; // walk caches: stage 1 levels 0 to 3, stage 2 level 0
  localparam int TCU_FIXED_SRC = 8; // control unit sources outside the walk caches
  localparam int TCU_NSRC = TCU_FIXED_SRC + 2 * WC_NUM; // all control unit sources
  localparam int TBU_NSRC = 4; // buffer unit sources

  // ***************************************************************
  // event codes
  // ***************************************************************
  localparam logic [CODE_W-1:0] EV_CYCLE = 8'h00; // clock cycles, both unit types
  localparam logic [CODE_W-1:0] EV_TXN = 8'h01; // requests or issued transactions
  localparam logic [CODE_W-1:0] EV_TLB_MISS = 8'h02; // uncached table walk or non-speculative request
  localparam logic [CODE_W-1:0] EV_CFG_MISS = 8'h03; // uncached configuration walk
  localparam logic [CODE_W-1:0] EV_TT_ACCESS = 8'h04; // table walk memory access
  localparam logic [CODE_W-1:0] EV_CFG_ACCESS = 8'h05; // configuration walk memory access
  localparam logic [CODE_W-1:0] EV_TCU_ATS = 8'h06; // requests from the root complex master
  localparam logic [CODE_W-1:0] EV_TBU_ATS = 8'h07; // pre-translated issued transactions
  localparam logic [CODE_W-1:0] EV_WC_BASE = 8'h80; // lookup of walk cache i is base plus 2i
  localparam logic [CODE_W-1:0] EV_WC_MISS_OFS = 8'h01; // miss code sits one above lookup
  localparam logic [CODE_W-1:0] EV_S2L0_MISS = 8'h89; // stage-2 level-0 walk cache miss

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000; // counters after reset

  // ***************************************************************
  // carriers
  // ***************************************************************
  // one occurrence of an event with its attributes
  typedef struct packed {
    logic valid; // occurrence this cycle
    logic spec; // speculative transaction or translation
    logic term; // terminated transaction or translation fault
    logic [SID_W-1:0] sid; // stream identifier
  } tpm_ev_t;

  // one candidate increment as the counters see it
  typedef struct packed {
    logic valid;
    logic filterable;
    logic [CODE_W-1:0] code;
    logic [SID_W-1:0] sid;
  } tpm_src_t;

  // control unit event inputs
  typedef struct packed {
    tpm_ev_t tbu_req; // request from a buffer unit master
    tpm_ev_t ats_req; // request from a root complex translation master
    tpm_ev_t tlb_walk; // request that walked uncached table entries
    tpm_ev_t cfg_walk; // request that walked uncached configuration entries
    tpm_ev_t tt_access; // table walk memory access
    tpm_ev_t cfg_access; // configuration walk memory access
    tpm_ev_t [WC_NUM-1:0] wc_lookup; // walk cache lookups, index is the cache
    tpm_ev_t [WC_NUM-1:0] wc_miss; // walk cache lookups that missed
  } tpm_tcu_ev_t;

  // buffer unit event inputs
  typedef struct packed {
    tpm_ev_t dn_txn; // transaction issued on the downstream master port
    logic dn_txn_ats; // that transaction was already translated
    tpm_ev_t xlat_req; // translation request sent to the control unit
  } tpm_tbu_ev_t;

  // per monitor configuration, held by the surrounding logic
  typedef struct packed {
    logic [NUM_CNT-1:0][CODE_W-1:0] sel_code; // event code per counter
    logic filt_en; // stream filter enable
    logic [SID_W-1:0] filt_sid; // stream filter register value
    logic [NUM_CNT-1:0] clear; // one-cycle clear per counter
  } tpm_mon_cfg_t;

  typedef logic [NUM_CNT-1:0][CNT_W-1:0] tpm_cnt_vec_t;

endpackage

// ### src/tpm_event_counter.sv
`timescale 1ns/1ps
// ***************************************************************
// one counter: sums the matching occurrences of a cycle
// ***************************************************************
module tpm_event_counter #(
  parameter int NSRC = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire tpm_pkg::tpm_src_t [NSRC-1:0] src_i,
  input wire logic [tpm_pkg::CODE_W-1:0] sel_code_i,
  input wire logic filt_en_i,
  input wire logic [tpm_pkg::SID_W-1:0] filt_sid_i,
  input wire logic clear_i,
  output logic [tpm_pkg::CNT_W-1:0] count_o
);
  import tpm_pkg::*;

  logic [CNT_W-1:0] count_reg; // running total
  logic [CNT_W-1:0] count_next; // total after this cycle
  logic [CNT_W-1:0] inc; // matching occurrences this cycle

  // count every source whose code is selected and that passes the filter
  always_comb begin
    inc = '0;
    for (int i = 0; i < NSRC; i++) begin
      // spec and term attributes are not looked at: such events still count [RQ3] [RQ4]
      if (src_i[i].valid && (src_i[i].code == sel_code_i) &&
          (!src_i[i].filterable || !filt_en_i || (src_i[i].sid == filt_sid_i))) begin // [RQ2]
        inc = inc + CNT_W'(1); // [RQ19]
      end
    end
    // a clear keeps this cycle's occurrences so none is lost
    if (clear_i) begin
      count_next = inc;
    end else begin
      count_next = count_reg + inc; // [RQ19]
    end
  end

  // register only
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_reg <= CNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_o = count_reg;

endmodule

// ### src/tpm_monitor_top.sv
`timescale 1ns/1ps
// Function
// [RQ1] one control monitor, one per buffer unit
// [RQ2] filter drops filterable events of other streams
// [RQ3] speculative events still pass the filter
// [RQ4] terminated or faulted events still pass filter
// [RQ5] code 0x0 counts ungated cycles, never filtered
// [RQ6] control 0x1 counts all translation requests
// [RQ7] control 0x2 counts uncached table walks
// [RQ8] control 0x3 counts uncached configuration walks
// [RQ9] control 0x4 counts table walk accesses
// [RQ10] control 0x5 counts configuration walk accesses
// [RQ11] control 0x6 counts root complex requests only
// [RQ12] buffer 0x1 counts downstream issued transactions
// [RQ13] buffer 0x2 counts non-speculative translation requests
// [RQ14] buffer 0x7 counts pre-translated downstream transactions
// [RQ15] even codes 0x80-0x86 count stage-1 lookups
// [RQ16] odd codes 0x81-0x87 count stage-1 misses
// [RQ17] code 0x88 counts stage-2 level-0 lookups
// [RQ18] code 0x89 counts stage-2 level-0 misses
// [RQ19] counters add selected occurrences; unknown codes idle
module tpm_monitor_top (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire tpm_pkg::tpm_tcu_ev_t tcu_ev_i,
  input wire logic tcu_clk_gated_i,
  input wire tpm_pkg::tpm_mon_cfg_t tcu_cfg_i,
  output tpm_pkg::tpm_cnt_vec_t tcu_count_o,
  input wire tpm_pkg::tpm_tbu_ev_t [tpm_pkg::NUM_TBU-1:0] tbu_ev_i,
  input wire logic [tpm_pkg::NUM_TBU-1:0] tbu_clk_gated_i,
  input wire tpm_pkg::tpm_mon_cfg_t [tpm_pkg::NUM_TBU-1:0] tbu_cfg_i,
  output tpm_pkg::tpm_cnt_vec_t [tpm_pkg::NUM_TBU-1:0] tbu_count_o
);
  import tpm_pkg::*;

  // ***************************************************************
  // source building
  // ***************************************************************
  // turns an event input into a counter candidate
  function automatic tpm_src_t mk_src(input logic valid, input logic filterable,
                                      input logic [CODE_W-1:0] code, input logic [SID_W-1:0] sid);
    tpm_src_t s;
    s.valid = valid;
    s.filterable = filterable;
    s.code = code;
    s.sid = sid;
    return s;
  endfunction

  tpm_src_t [TCU_NSRC-1:0] tcu_src; // every control unit candidate of the cycle

  // control unit candidates; two request ports may both fire, so 0x1 can add two
  always_comb begin
    // cycle count stops once the gating handshake has completed [RQ5]
    tcu_src[0] = mk_src(!tcu_clk_gated_i, 1'b0, EV_CYCLE, '0); // [RQ5]
    tcu_src[1] = mk_src(tcu_ev_i.tbu_req.valid, 1'b1, EV_TXN, tcu_ev_i.tbu_req.sid); // [RQ6]
    tcu_src[2] = mk_src(tcu_ev_i.ats_req.valid, 1'b1, EV_TXN, tcu_ev_i.ats_req.sid); // [RQ6]
    tcu_src[3] = mk_src(tcu_ev_i.tlb_walk.valid, 1'b1, EV_TLB_MISS, tcu_ev_i.tlb_walk.sid); // [RQ7]
    tcu_src[4] = mk_src(tcu_ev_i.cfg_walk.valid, 1'b1, EV_CFG_MISS, tcu_ev_i.cfg_walk.sid); // [RQ8]
    tcu_src[5] = mk_src(tcu_ev_i.tt_access.valid, 1'b1, EV_TT_ACCESS, tcu_ev_i.tt_access.sid); // [RQ9]
    tcu_src[6] = mk_src(tcu_ev_i.cfg_access.valid, 1'b1, EV_CFG_ACCESS, tcu_ev_i.cfg_access.sid); // [RQ10]
    // buffer unit requests never reach this code
    tcu_src[7] = mk_src(tcu_ev_i.ats_req.valid, 1'b1, EV_TCU_ATS, tcu_ev_i.ats_req.sid); // [RQ11]
    // walk caches: lookup on even code, miss one above it [RQ15] [RQ16] [RQ17] [RQ18]
    for (int w = 0; w < WC_NUM; w++) begin
      tcu_src[TCU_FIXED_SRC + 2 * w] = mk_src(tcu_ev_i.wc_lookup[w].valid, 1'b1,
                                              EV_WC_BASE + CODE_W'(2 * w), tcu_ev_i.wc_lookup[w].sid);
      tcu_src[TCU_FIXED_SRC + 2 * w + 1] = mk_src(tcu_ev_i.wc_miss[w].valid, 1'b1,
                                                  EV_WC_BASE + CODE_W'(2 * w) + EV_WC_MISS_OFS,
                                                  tcu_ev_i.wc_miss[w].sid);
    end
  end

  // ***************************************************************
  // control unit monitor
  // ***************************************************************
  // counters share the filter; each picks its own code
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CNT; gc++) begin : g_tcu_cnt
      tpm_event_counter #(
        .NSRC(TCU_NSRC)
      ) u_cnt (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .src_i(tcu_src),
        .sel_code_i(tcu_cfg_i.sel_code[gc]),
        .filt_en_i(tcu_cfg_i.filt_en),
        .filt_sid_i(tcu_cfg_i.filt_sid),
        .clear_i(tcu_cfg_i.clear[gc]),
        .count_o(tcu_count_o[gc])
      );
    end
  endgenerate

  // ***************************************************************
  // buffer unit monitors
  // ***************************************************************
  // each buffer unit owns a monitor of its own [RQ1]
  genvar gt;
  genvar gk;
  generate
    for (gt = 0; gt < NUM_TBU; gt++) begin : g_tbu
      tpm_src_t [TBU_NSRC-1:0] tbu_src; // this unit's candidates

      // buffer unit candidates of the cycle
      always_comb begin
        tbu_src[0] = mk_src(!tbu_clk_gated_i[gt], 1'b0, EV_CYCLE, '0); // [RQ5]
        tbu_src[1] = mk_src(tbu_ev_i[gt].dn_txn.valid, 1'b1, EV_TXN, tbu_ev_i[gt].dn_txn.sid); // [RQ12]
        // speculative requests are dropped here, not by the filter
        tbu_src[2] = mk_src(tbu_ev_i[gt].xlat_req.valid && !tbu_ev_i[gt].xlat_req.spec, 1'b1,
                            EV_TLB_MISS, tbu_ev_i[gt].xlat_req.sid); // [RQ13]
        tbu_src[3] = mk_src(tbu_ev_i[gt].dn_txn.valid && tbu_ev_i[gt].dn_txn_ats, 1'b1,
                            EV_TBU_ATS, tbu_ev_i[gt].dn_txn.sid); // [RQ14]
      end

      for (gk = 0; gk < NUM_CNT; gk++) begin : g_cnt
        tpm_event_counter #(
          .NSRC(TBU_NSRC)
        ) u_cnt (
          .sys_clk_i(sys_clk_i),
          .rst_b_i(rst_b_i),
          .src_i(tbu_src),
          .sel_code_i(tbu_cfg_i[gt].sel_code[gk]),
          .filt_en_i(tbu_cfg_i[gt].filt_en),
          .filt_sid_i(tbu_cfg_i[gt].filt_sid),
          .clear_i(tbu_cfg_i[gt].clear[gk]),
          .count_o(tbu_count_o[gt][gk])
        );
      end
    end
  endgenerate

  // ***************************************************************
  // checks on counter 0 of the control unit and of buffer unit 0
  // ***************************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  logic [CNT_W-1:0] tc0; // control unit counter 0
  logic [CNT_W-1:0] bc0; // buffer unit 0 counter 0
  logic t_run; // control counter 0 not cleared
  logic b_run; // buffer counter 0 not cleared
  assign tc0 = tcu_count_o[0];
  assign bc0 = tbu_count_o[0][0];
  assign t_run = !tcu_cfg_i.clear[0];
  assign b_run = !tbu_cfg_i[0].clear[0];

  // ungated cycles add one even with the filter on
  cyc_count_a: assert property ( // [RQ5]
    (t_run && tcu_cfg_i.sel_code[0] == EV_CYCLE && !tcu_clk_gated_i && tcu_cfg_i.filt_en)
    |=> (tc0 == $past(tc0) + CNT_W'(1)))
    else $error("cycle count did not step");

  // a gated stretch of three cycles leaves the count alone
  cyc_gated_a: assert property ( // [RQ5]
    (t_run && tcu_cfg_i.sel_code[0] == EV_CYCLE && tcu_clk_gated_i) [*3]
    |=> (tc0 == $past(tc0, 3)))
    else $error("gated cycles were counted");

  // both request ports in one cycle add two
  txn_both_a: assert property ( // [RQ6]
    (t_run && tcu_cfg_i.sel_code[0] == EV_TXN && !tcu_cfg_i.filt_en &&
     tcu_ev_i.tbu_req.valid && tcu_ev_i.ats_req.valid)
    |=> (tc0 - $past(tc0) == CNT_W'(2)))
    else $error("two requests did not add two");

  // buffer unit requests never feed the root complex code
  ats_only_a: assert property ( // [RQ11]
    (t_run && tcu_cfg_i.sel_code[0] == EV_TCU_ATS && tcu_ev_i.tbu_req.valid && !tcu_ev_i.ats_req.valid)
    |=> $stable(tc0))
    else $error("buffer request counted as root complex request");

  // another stream's access is filtered out
  filt_drop_a: assert property ( // [RQ2]
    (t_run && tcu_cfg_i.sel_code[0] == EV_TT_ACCESS && tcu_cfg_i.filt_en &&
     tcu_ev_i.tt_access.sid != tcu_cfg_i.filt_sid)
    |=> $stable(tc0))
    else $error("filtered access was counted");

  // speculative or faulted walk on the selected stream still counts
  spec_kept_a: assert property ( // [RQ3] [RQ4]
    (t_run && tcu_cfg_i.sel_code[0] == EV_TLB_MISS && tcu_cfg_i.filt_en && tcu_ev_i.tlb_walk.valid &&
     (tcu_ev_i.tlb_walk.spec || tcu_ev_i.tlb_walk.term) && tcu_ev_i.tlb_walk.sid == tcu_cfg_i.filt_sid)
    |=> (tc0 == $past(tc0) + CNT_W'(1)))
    else $error("speculative or faulted walk was dropped");

  // stage-2 level-0 miss lands on its code
  wc_miss_a: assert property ( // [RQ18]
    (t_run && tcu_cfg_i.sel_code[0] == EV_S2L0_MISS && !tcu_cfg_i.filt_en && tcu_ev_i.wc_miss[WC_NUM-1].valid)
    |=> (tc0 == $past(tc0) + CNT_W'(1)))
    else $error("stage-2 level-0 miss not counted");

  // code 0x07, which the control unit lacks, never moves its counter
  bad_code_a: assert property ( // [RQ19]
    (t_run && tcu_cfg_i.sel_code[0] == EV_TBU_ATS) [*2]
    |=> (tc0 == $past(tc0, 2)))
    else $error("unimplemented code counted");

  // speculative translation requests are excluded in the buffer unit
  tbu_spec_a: assert property ( // [RQ13]
    (b_run && tbu_cfg_i[0].sel_code[0] == EV_TLB_MISS && tbu_ev_i[0].xlat_req.spec)
    |=> $stable(bc0))
    else $error("speculative request counted");

  // pre-translated issued transaction adds one
  tbu_ats_a: assert property ( // [RQ14]
    (b_run && tbu_cfg_i[0].sel_code[0] == EV_TBU_ATS && !tbu_cfg_i[0].filt_en &&
     tbu_ev_i[0].dn_txn.valid && tbu_ev_i[0].dn_txn_ats)
    |=> (bc0 == $past(bc0) + CNT_W'(1)))
    else $error("pre-translated transaction not counted");

  // an uncached table walk with the filter off adds one
  tlb_walk_a: assert property ( // [RQ7]
    (t_run && tcu_cfg_i.sel_code[0] == EV_TLB_MISS && !tcu_cfg_i.filt_en && tcu_ev_i.tlb_walk.valid)
    |=> (tc0 == $past(tc0) + CNT_W'(1)))
    else $error("uncached table walk not counted");

  // an uncached configuration walk with the filter off adds one
  cfg_walk_a: assert property ( // [RQ8]
    (t_run && tcu_cfg_i.sel_code[0] == EV_CFG_MISS && !tcu_cfg_i.filt_en && tcu_ev_i.cfg_walk.valid)
    |=> (tc0 == $past(tc0) + CNT_W'(1)))
    else $error("uncached configuration walk not counted");

  // a table walk memory access with the filter off adds one
  tt_access_a: assert property ( // [RQ9]
    (t_run && tcu_cfg_i.sel_code[0] == EV_TT_ACCESS && !tcu_cfg_i.filt_en && tcu_ev_i.tt_access.valid)
    |=> (tc0 == $past(tc0) + CNT_W'(1)))
    else $error("table walk access not counted");

  // a configuration walk memory access with the filter off adds one
  cfg_access_a: assert property ( // [RQ10]
    (t_run && tcu_cfg_i.sel_code[0] == EV_CFG_ACCESS && !tcu_cfg_i.filt_en && tcu_ev_i.cfg_access.valid)
    |=> (tc0 == $past(tc0) + CNT_W'(1)))
    else $error("configuration walk access not counted");

  // a stage-1 level-0 lookup lands on the base code
  s1_lookup_a: assert property ( // [RQ15]
    (t_run && tcu_cfg_i.sel_code[0] == EV_WC_BASE && !tcu_cfg_i.filt_en && tcu_ev_i.wc_lookup[0].valid)
    |=> (tc0 == $past(tc0) + CNT_W'(1)))
    else $error("stage-1 lookup not counted");

  // a stage-1 level-0 miss lands one above the base code
  s1_miss_a: assert property ( // [RQ16]
    (t_run && tcu_cfg_i.sel_code[0] == (EV_WC_BASE + EV_WC_MISS_OFS) && !tcu_cfg_i.filt_en &&
     tcu_ev_i.wc_miss[0].valid)
    |=> (tc0 == $past(tc0) + CNT_W'(1)))
    else $error("stage-1 miss not counted");

  // a stage-2 level-0 lookup lands one below its miss code
  s2_lookup_a: assert property ( // [RQ17]
    (t_run && tcu_cfg_i.sel_code[0] == (EV_S2L0_MISS - EV_WC_MISS_OFS) && !tcu_cfg_i.filt_en &&
     tcu_ev_i.wc_lookup[WC_NUM-1].valid)
    |=> (tc0 == $past(tc0) + CNT_W'(1)))
    else $error("stage-2 lookup not counted");

  // a downstream issued transaction adds one in the buffer unit
  dn_txn_a: assert property ( // [RQ12]
    (b_run && tbu_cfg_i[0].sel_code[0] == EV_TXN && !tbu_cfg_i[0].filt_en && tbu_ev_i[0].dn_txn.valid)
    |=> (bc0 == $past(bc0) + CNT_W'(1)))
    else $error("downstream transaction not counted");

  // main scenarios
  cyc_run_c: cover property (t_run && tcu_cfg_i.sel_code[0] == EV_CYCLE && !tcu_clk_gated_i [*4]);
  two_req_c: cover property (tcu_ev_i.tbu_req.valid && tcu_ev_i.ats_req.valid);
  filt_hit_c: cover property (tcu_cfg_i.filt_en && tcu_ev_i.tt_access.valid &&
                              tcu_ev_i.tt_access.sid == tcu_cfg_i.filt_sid);
  tbu_ats_c: cover property (tbu_ev_i[0].dn_txn.valid && tbu_ev_i[0].dn_txn_ats);

endmodule

// ### verif/tpm_monitor_top_tb.sv
`timescale 1ns/1ps
// ***************************************************************
// self-checking bench of the performance event monitors
// ***************************************************************
module tpm_monitor_top_tb;
  import tpm_pkg::*;

  localparam int MAX_CYCLES = 3000; // sweep takes 1920 cycles, margin for reset
  localparam int RUN_CYCLES = 1920; // 24 codes, 80 cycles each
  localparam logic [SID_W-1:0] FILT_SID = 24'h00_5a3c; // selected stream

  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0; // held low over the first five edges
  tpm_tcu_ev_t tcu_ev;
  logic tcu_gated;
  tpm_mon_cfg_t tcu_cfg;
  tpm_cnt_vec_t tcu_count;
  tpm_tbu_ev_t [NUM_TBU-1:0] tbu_ev;
  logic [NUM_TBU-1:0] tbu_gated;
  tpm_mon_cfg_t [NUM_TBU-1:0] tbu_cfg;
  tpm_cnt_vec_t [NUM_TBU-1:0] tbu_count;
  logic [CNT_W-1:0] exp_tcu [NUM_CNT]; // model counts, control unit
  logic [CNT_W-1:0] exp_tbu [NUM_TBU][NUM_CNT]; // model counts, buffer units
  logic [15:0] lfsr_q = 16'hdcbe; // fixed seed keeps runs repeatable
  int error_cnt = 0;
  int total_checks = 0;
  int cycle_cnt = 0;

  always #2 sys_clk_i = ~sys_clk_i; // 250 MHz

  tpm_monitor_top u_dut (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .tcu_ev_i(tcu_ev),
    .tcu_clk_gated_i(tcu_gated),
    .tcu_cfg_i(tcu_cfg),
    .tcu_count_o(tcu_count),
    .tbu_ev_i(tbu_ev),
    .tbu_clk_gated_i(tbu_gated),
    .tbu_cfg_i(tbu_cfg),
    .tbu_count_o(tbu_count)
  );

  // ***************************************************************
  // helpers
  // ***************************************************************
  // galois-free fibonacci step, taps 16 14 13 11
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  // sid is half the time the selected stream so the filter both passes and drops
  function automatic tpm_ev_t rand_ev(input logic force_all);
    tpm_ev_t e;
    logic [15:0] r;
    r = rnd();
    e.valid = force_all | r[0] | r[4];
    e.spec = force_all | r[1];
    e.term = force_all | r[2];
    e.sid = (force_all | r[3]) ? FILT_SID : {8'h00, rnd()};
    return e;
  endfunction

  // sweep table: 0x00-0x07 then 0x80-0x8f, unimplemented codes among them
  function automatic logic [CODE_W-1:0] code_of(input int idx);
    return (idx < 8) ? CODE_W'(idx) : CODE_W'(8'h80 + idx - 8);
  endfunction

  function automatic int passes(input tpm_ev_t e, input tpm_mon_cfg_t cfg);
    return int'(e.valid && (!cfg.filt_en || e.sid == cfg.filt_sid));
  endfunction

  // expected increments of one control unit counter this cycle
  function automatic int tcu_inc(input logic [CODE_W-1:0] code);
    int n;
    n = 0;
    case (code)
      8'h00: n = int'(!tcu_gated);
      8'h01: n = passes(tcu_ev.tbu_req, tcu_cfg) + passes(tcu_ev.ats_req, tcu_cfg);
      8'h02: n = passes(tcu_ev.tlb_walk, tcu_cfg);
      8'h03: n = passes(tcu_ev.cfg_walk, tcu_cfg);
      8'h04: n = passes(tcu_ev.tt_access, tcu_cfg);
      8'h05: n = passes(tcu_ev.cfg_access, tcu_cfg);
      8'h06: n = passes(tcu_ev.ats_req, tcu_cfg);
      default: begin
        // walk caches: lookup on even, miss on odd, 0x80-0x89 only
        if (code >= 8'h80 && code <= 8'h89) begin
          n = code[0] ? passes(tcu_ev.wc_miss[code[3:1]], tcu_cfg)
                      : passes(tcu_ev.wc_lookup[code[3:1]], tcu_cfg);
        end
      end
    endcase
    return n;
  endfunction

  // expected increments of one buffer unit counter this cycle
  function automatic int tbu_inc(input int u, input logic [CODE_W-1:0] code);
    int n;
    n = 0;
    case (code)
      8'h00: n = int'(!tbu_gated[u]);
      8'h01: n = passes(tbu_ev[u].dn_txn, tbu_cfg[u]);
      8'h02: n = passes(tbu_ev[u].xlat_req, tbu_cfg[u]) * int'(!tbu_ev[u].xlat_req.spec);
      8'h07: n = passes(tbu_ev[u].dn_txn, tbu_cfg[u]) * int'(tbu_ev[u].dn_txn_ats);
      default: n = 0;
    endcase
    return n;
  endfunction

  task automatic check(input string name, input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ***************************************************************
  // stimulus of one cycle and the model update it implies
  // ***************************************************************
  task automatic drive_cycle(input int k);
    logic force_all;
    logic [15:0] r;
    // every 97th cycle all sources fire speculative, terminated, on the stream
    force_all = (k % 97 == 5);
    tcu_ev.tbu_req = rand_ev(force_all);
    tcu_ev.ats_req = rand_ev(force_all);
    tcu_ev.tlb_walk = rand_ev(force_all);
    tcu_ev.cfg_walk = rand_ev(force_all);
    tcu_ev.tt_access = rand_ev(force_all);
    tcu_ev.cfg_access = rand_ev(force_all);
    for (int i = 0; i < WC_NUM; i++) begin
      tcu_ev.wc_lookup[i] = rand_ev(force_all);
      tcu_ev.wc_miss[i] = rand_ev(force_all);
    end
    r = rnd();
    tcu_gated = r[0] & r[1];
    tcu_cfg.filt_en = ((k / 20) % 2 == 1);
    tcu_cfg.filt_sid = FILT_SID;
    for (int c = 0; c < NUM_CNT; c++) begin
      r = rnd();
      tcu_cfg.sel_code[c] = code_of((k / 80 + 7 * c) % 24);
      tcu_cfg.clear[c] = (r[3:0] == 4'h0);
    end
    for (int u = 0; u < NUM_TBU; u++) begin
      r = rnd();
      tbu_ev[u].dn_txn = rand_ev(force_all);
      tbu_ev[u].dn_txn_ats = r[0];
      tbu_ev[u].xlat_req = rand_ev(force_all);
      tbu_gated[u] = r[1] & r[2];
      tbu_cfg[u].filt_en = ((k / 20) % 2 == u);
      tbu_cfg[u].filt_sid = FILT_SID;
      for (int c = 0; c < NUM_CNT; c++) begin
        tbu_cfg[u].sel_code[c] = code_of((k / 80 + 7 * c + 3 * u) % 24);
        tbu_cfg[u].clear[c] = (r[7 + 4 * c -: 4] == 4'h0);
      end
    end
    // a clear keeps the events of its own cycle
    for (int c = 0; c < NUM_CNT; c++) begin
      exp_tcu[c] = (tcu_cfg.clear[c] ? CNT_RST : exp_tcu[c]) + CNT_W'(tcu_inc(tcu_cfg.sel_code[c]));
      for (int u = 0; u < NUM_TBU; u++) begin
        exp_tbu[u][c] = (tbu_cfg[u].clear[c] ? CNT_RST : exp_tbu[u][c]) + CNT_W'(tbu_inc(u, tbu_cfg[u].sel_code[c]));
      end
    end
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    tcu_ev = '0;
    tcu_gated = 1'b0;
    tcu_cfg = '0;
    tbu_ev = '0;
    tbu_gated = '0;
    tbu_cfg = '0;
    for (int c = 0; c < NUM_CNT; c++) begin
      exp_tcu[c] = 32'h0000_0000;
      for (int u = 0; u < NUM_TBU; u++) begin
        exp_tbu[u][c] = 32'h0000_0000;
      end
    end
    repeat (5) @(posedge sys_clk_i);
    #1;
    rst_b_i = 1'b1;
    // counts land one edge after their events, so compare after each edge
    for (int k = 0; k < RUN_CYCLES; k++) begin
      drive_cycle(k);
      @(posedge sys_clk_i);
      #1;
      for (int c = 0; c < NUM_CNT; c++) begin
        check("tcu_count", tcu_count[c], exp_tcu[c]);
        for (int u = 0; u < NUM_TBU; u++) begin
          check("tbu_count", tbu_count[u][c], exp_tbu[u][c]);
        end
      end
    end
    tally_and_finish();
  end

  // ***************************************************************
  // hang guard
  // ***************************************************************
  always @(posedge sys_clk_i) begin
    cycle_cnt++;
    if (cycle_cnt >= MAX_CYCLES) begin
      error_cnt++;
      $display("timeout after %0d cycles", cycle_cnt);
      tally_and_finish();
    end
  end

endmodule
